/* src/vcp_ctrl_port.sv */
// Purpose: Control-side pin logic of a dual-channel voice codec
// Assumes: Pins are asynchronous to ref_clk_i and slow enough to edge-detect
// Notes:   Serial frames are 8-bit bytes; the command layer sits in software
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vcp_ctrl_port
   import vcp_pkg::*;
(
   input  wire logic        ref_clk_i,            // 40 MHz system clock
   input  wire logic        rst_i,                // Async reset, active high
   input  wire logic        wb_cyc_i,             // Wishbone cycle
   input  wire logic        wb_stb_i,             // Wishbone strobe
   input  wire logic        wb_we_i,              // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,             // Byte address
   input  wire logic [3:0]  wb_sel_i,             // Byte enables
   input  wire logic [31:0] wb_dat_i,             // Write data
   output logic      [31:0] wb_dat_o,             // Read data
   output logic             wb_ack_o,             // Acknowledge
   output logic             irq_o,                // Level interrupt, high active
   input  wire logic        ctrl_shift_clock_i,   // Control shift clock pin
   input  wire logic        ctrl_data_in_i,       // Control data input pin
   input  wire logic        chip_select_n_i,      // Chip select, active low
   output logic             ctrl_data_out_o,      // Control data output level
   output logic             ctrl_data_out_oe_o,   // Control data output enable
   input  wire logic        int_n_i,              // Interrupt pin level seen
   output logic             int_n_o,              // Interrupt pin drive level
   output logic             int_n_oe_o,           // Interrupt pin enable
   input  wire logic        chip_reset_n_i,       // Reset pin, active low
   input  wire logic [1:0]  fault_n_i,            // Channel fault pins, low active
   output logic      [1:0]  line_state_ctl_a_o,   // Line state bit a per channel
   output logic      [1:0]  line_state_ctl_b_o,   // Line state bit b per channel
   output logic      [1:0]  line_state_ctl_c_o,   // Line state bit c per channel
   output logic             regulator_clock_out_o,// Switching regulator clock
   input  wire logic        pcm_clk_i,            // Highway bit clock
   input  wire logic        frame_sync_i,         // Highway frame sync
   input  wire logic        rx_highway_in_i,      // Receive highway data
   output logic             tx_highway_out_o,     // Transmit highway data
   output logic             tx_highway_oe_o,      // Transmit highway enable
   output logic      [2:0]  addr_strap_o          // Captured address straps
);

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction
   function automatic logic slot_hit(input logic [9:0] pos, input logic [7:0] slot);
      return pos[9:3] == slot[6:0];
   endfunction
   vcp_pin_t    pin_raw;
   vcp_pin_t    meta_q;
   vcp_pin_t    sync_q;
   vcp_pin_t    prev_q;
   logic        srst;
   logic [7:0]  ctrl_q;
   logic [5:0]  line_q;
   logic [7:0]  rxbyte_q;
   logic [7:0]  txbyte_q;
   logic [2:0]  status_q;
   logic [2:0]  mask_q;
   logic [7:0]  cfg2_q;
   logic [15:0] slots_q;
   logic [15:0] txsamp_q;
   logic [15:0] rxsamp_q;
   logic [2:0]  strap_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic [7:0]  rx_sh_q;
   logic [7:0]  tx_sh_q;
   logic [2:0]  bit_q;
   logic        arm_q;
   logic [7:0]  div_q;
   logic        regclk_q;
   logic [9:0]  pos_q;
   logic [7:0]  hw_rx_q [2];
   logic        hw_tx_q;
   logic        hw_oe_q;
   assign pin_raw = '{sck: ctrl_shift_clock_i, din: ctrl_data_in_i, int_in: int_n_i,
                      cs_n: chip_select_n_i, rst_n: chip_reset_n_i, fault_n: fault_n_i,
                      pclk: pcm_clk_i, fs: frame_sync_i, rxhw: rx_highway_in_i};

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= PIN_IDLE;
         sync_q <= PIN_IDLE;
         prev_q <= PIN_IDLE;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign srst = ~sync_q.rst_n;
   wire inband   = ctrl_q[C_INBAND];
   wire sel_ok   = ~sync_q.cs_n & ~inband;
   wire sck_rise = sel_ok & sync_q.sck & ~prev_q.sck;
   wire sck_fall = sel_ok & ~sync_q.sck & prev_q.sck;
   wire cs_fall  = ~sync_q.cs_n & prev_q.cs_n;
   wire byte_end = sck_rise & (bit_q == BIT_LAST);
   wire p_rise   = sync_q.pclk & ~prev_q.pclk;
   wire p_fall   = ~sync_q.pclk & prev_q.pclk;
   wire [9:0] pos_n = sync_q.fs ? 10'h000 : pos_q + POS_ONE;

   // Wishbone: ack one cycle after the request; writes commit on the ack edge
   wire req   = wb_cyc_i & wb_stb_i;
   wire wr_en = req & wb_we_i & ack_q;
   wire wr_ctrl   = wr_en & (wb_adr_i == A_CTRL);
   wire wr_line   = wr_en & (wb_adr_i == A_LINE);
   wire wr_tx     = wr_en & (wb_adr_i == A_TXBYTE);
   wire wr_status = wr_en & (wb_adr_i == A_STATUS);
   wire wr_mask   = wr_en & (wb_adr_i == A_MASK);
   wire wr_cfg2   = wr_en & (wb_adr_i == A_CFG2);
   wire wr_slots  = wr_en & (wb_adr_i == A_SLOTS);
   wire wr_txsamp = wr_en & (wb_adr_i == A_TXSAMP);
   wire [31:0] wdat = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   logic [31:0] rdata;
   always_comb begin
      if (wb_adr_i == A_CTRL) begin
         rdata = {24'h000000, ctrl_q};
      end else if (wb_adr_i == A_LINE) begin
         rdata = {26'h0000000, line_q};
      end else if (wb_adr_i == A_RXBYTE) begin
         rdata = {24'h000000, rxbyte_q};
      end else if (wb_adr_i == A_TXBYTE) begin
         rdata = {24'h000000, txbyte_q};
      end else if (wb_adr_i == A_STATUS) begin
         rdata = {29'h00000000, status_q};
      end else if (wb_adr_i == A_MASK) begin
         rdata = {29'h00000000, mask_q};
      end else if (wb_adr_i == A_STRAP) begin
         rdata = {27'h0000000, ~sync_q.fault_n, strap_q};
      end else if (wb_adr_i == A_CFG2) begin
         rdata = {24'h000000, cfg2_q};
      end else if (wb_adr_i == A_SLOTS) begin
         rdata = {16'h0000, slots_q};
      end else if (wb_adr_i == A_TXSAMP) begin
         rdata = {16'h0000, txsamp_q};
      end else if (wb_adr_i == A_RXSAMP) begin
         rdata = {16'h0000, rxsamp_q};
      end else begin
         rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            dat_q <= rdata;
         end
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   // Software registers; the reset pin clears them like the bus reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q   <= 8'h00;
         line_q   <= 6'h00;
         txbyte_q <= 8'h00;
         mask_q   <= 3'h0;
         cfg2_q   <= 8'h00;
         slots_q  <= 16'h0000;
         txsamp_q <= 16'h0000;
      end else if (srst) begin
         ctrl_q   <= 8'h00;
         line_q   <= 6'h00;
         txbyte_q <= 8'h00;
         mask_q   <= 3'h0;
         cfg2_q   <= 8'h00;
         slots_q  <= 16'h0000;
         txsamp_q <= 16'h0000;
      end else begin
         if (wr_ctrl)   ctrl_q   <= wdat[7:0];
         if (wr_line)   line_q   <= wdat[5:0];
         if (wr_tx)     txbyte_q <= wdat[7:0];
         if (wr_mask)   mask_q   <= wdat[2:0];
         if (wr_cfg2)   cfg2_q   <= wdat[7:0];
         if (wr_slots)  slots_q  <= wdat[15:0];
         if (wr_txsamp) txsamp_q <= wdat[15:0];
      end
   end

   // Sticky events; a new event wins over a same-cycle write-one clear
   wire [2:0] events = {~sync_q.fault_n[1], ~sync_q.fault_n[0], byte_end};
   wire [2:0] clr    = wr_status ? wdat[2:0] : 3'h0;
   wire       svc    = |(status_q & mask_q);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= 3'h0;
      end else if (srst) begin
         status_q <= 3'h0;
      end else begin
         status_q <= (status_q & ~clr) | events;
      end
   end
   assign irq_o = svc;
   // Serial control port: sample on rising, present next bit after falling
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_sh_q  <= 8'h00;
         rxbyte_q <= 8'h00;
         tx_sh_q  <= 8'h00;
         bit_q    <= 3'h0;
         arm_q    <= 1'b0;
      end else if (srst) begin
         rx_sh_q  <= 8'h00;
         rxbyte_q <= 8'h00;
         tx_sh_q  <= 8'h00;
         bit_q    <= 3'h0;
         arm_q    <= 1'b0;
      end else begin
         if (sck_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], sync_q.din};
            bit_q   <= bit_q + 3'h1;
         end
         if (byte_end) begin
            rxbyte_q <= {rx_sh_q[6:0], sync_q.din};
         end
         if (cs_fall) begin
            tx_sh_q <= txbyte_q;
            bit_q   <= 3'h0;
         end else if (sck_fall) begin
            tx_sh_q <= (bit_q == 3'h0) ? txbyte_q : {tx_sh_q[6:0], 1'b0};
         end
         if (sync_q.cs_n) begin
            arm_q <= 1'b0;
         end else if (wr_tx) begin
            arm_q <= 1'b1;
         end
      end
   end

   // Without the drive bit the output only drives for an armed read,
   // which is what keeps a shared data wire free for the host
   assign ctrl_data_out_o    = tx_sh_q[7];
   assign ctrl_data_out_oe_o = sel_ok & (arm_q | cfg2_q[CFG2_DRV]);

   // Interrupt pin: straps in in-band mode, otherwise low on service
   assign int_n_o    = ~svc;
   assign int_n_oe_o = ~inband & (ctrl_q[C_PUSHPL] | svc);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_q <= 3'h0;
      end else if (inband) begin
         strap_q <= {sync_q.int_in, sync_q.din, sync_q.sck};
      end
   end
   assign addr_strap_o       = strap_q;
   assign line_state_ctl_a_o = {line_q[3], line_q[0]};
   assign line_state_ctl_b_o = {line_q[4], line_q[1]};
   assign line_state_ctl_c_o = {line_q[5], line_q[2]};
   // Regulator clock; integer division leaves both rates a little fast
   wire [7:0] half = ctrl_q[C_SLOWCLK] ? REG_SLOW_HALF : REG_FAST_HALF;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q    <= 8'h00;
         regclk_q <= 1'b0;
      end else if (srst | ~ctrl_q[C_REGEN]) begin
         div_q    <= 8'h00;
         regclk_q <= 1'b0;
      end else if (div_q + CNT_ONE >= half) begin
         div_q    <= 8'h00;
         regclk_q <= ~regclk_q;
      end else begin
         div_q <= div_q + CNT_ONE;
      end
   end

   assign regulator_clock_out_o = regclk_q;
   // Highway: drive on bit clock rise, sample on fall, slots of eight bits
   wire hit0_n = slot_hit(pos_n, slots_q[7:0]);
   wire hit1_n = slot_hit(pos_n, slots_q[15:8]);
   wire [7:0] samp_n = hit0_n ? txsamp_q[7:0] : txsamp_q[15:8];
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pos_q      <= 10'h000;
         hw_tx_q    <= 1'b0;
         hw_oe_q    <= 1'b0;
         hw_rx_q[0] <= 8'h00;
         hw_rx_q[1] <= 8'h00;
         rxsamp_q   <= 16'h0000;
      end else if (srst) begin
         pos_q      <= 10'h000;
         hw_tx_q    <= 1'b0;
         hw_oe_q    <= 1'b0;
         hw_rx_q[0] <= 8'h00;
         hw_rx_q[1] <= 8'h00;
         rxsamp_q   <= 16'h0000;
      end else begin
         if (p_rise) begin
            pos_q   <= pos_n;
            hw_tx_q <= samp_n[BIT_LAST - pos_n[2:0]];
            hw_oe_q <= hit0_n | hit1_n;
         end
         if (p_fall) begin
            for (int c = 0; c < 2; c++) begin
               if (slot_hit(pos_q, slots_q[c*8 +: 8])) begin
                  hw_rx_q[c] <= {hw_rx_q[c][6:0], sync_q.rxhw};
                  if (pos_q[2:0] == BIT_LAST) begin
                     rxsamp_q[c*8 +: 8] <= {hw_rx_q[c][6:0], sync_q.rxhw};
                  end
               end
            end
         end
      end
   end

   assign tx_highway_out_o = hw_tx_q;
   assign tx_highway_oe_o  = hw_oe_q;
endmodule
`default_nettype wire

/* src/vcp_pkg.sv */
// Purpose: Shared constants and carriers for the voice codec control port
// Assumes: 40 MHz ref_clk_i, Wishbone classic slave with byte addresses
// Notes:   All pin inputs travel together in vcp_pin_t through one synchroniser
package vcp_pkg;
   localparam int          CLK_HZ        = 40_000_000;
   localparam int          REG_FAST_HZ   = 256_000;
   localparam int          REG_SLOW_HZ   = 85_300;
   localparam logic [7:0]  REG_FAST_HALF = 8'(CLK_HZ / (2 * REG_FAST_HZ));
   localparam logic [7:0]  REG_SLOW_HALF = 8'(CLK_HZ / (2 * REG_SLOW_HZ));

   localparam logic [7:0]  A_CTRL    = 8'h00;
   localparam logic [7:0]  A_LINE    = 8'h04;
   localparam logic [7:0]  A_RXBYTE  = 8'h08;
   localparam logic [7:0]  A_TXBYTE  = 8'h0C;
   localparam logic [7:0]  A_STATUS  = 8'h10;
   localparam logic [7:0]  A_MASK    = 8'h14;
   localparam logic [7:0]  A_STRAP   = 8'h18;
   localparam logic [7:0]  A_CFG2    = 8'h1C;
   localparam logic [7:0]  A_SLOTS   = 8'h20;
   localparam logic [7:0]  A_TXSAMP  = 8'h24;
   localparam logic [7:0]  A_RXSAMP  = 8'h28;

   localparam int          C_INBAND  = 0;
   localparam int          C_PUSHPL  = 1;
   localparam int          C_SLOWCLK = 2;
   localparam int          C_REGEN   = 3;
   localparam int          CFG2_DRV  = 7;
   localparam int          ST_BYTE   = 0;
   localparam int          ST_FLT0   = 1;
   localparam int          ST_FLT1   = 2;

   localparam logic [2:0]  BIT_LAST  = 3'h7;
   localparam logic [9:0]  POS_ONE   = 10'h001;
   localparam logic [7:0]  CNT_ONE   = 8'h01;

   typedef struct packed {
      logic       sck;
      logic       din;
      logic       int_in;
      logic       cs_n;
      logic       rst_n;
      logic [1:0] fault_n;
      logic       pclk;
      logic       fs;
      logic       rxhw;
   } vcp_pin_t;

   localparam vcp_pin_t PIN_IDLE = '{sck: 1'b0, din: 1'b0, int_in: 1'b1, cs_n: 1'b1,
                                     rst_n: 1'b0, fault_n: 2'h3, pclk: 1'b0,
                                     fs: 1'b0, rxhw: 1'b0};
endpackage

/* tb/vcp_ctrl_port_checker.sv */
// Purpose: Concurrent checks on the control port bus and pins
// Assumes: Sees only top ports; one ref_clk_i domain
// Notes:   Pin syncs add about three clocks, so pin windows allow slack
`timescale 1ns/1ps
`default_nettype none
module vcp_ctrl_port_checker (
   input  wire logic        ref_clk_i,             // Clock
   input  wire logic        rst_i,                 // Reset
   input  wire logic        wb_cyc_i,              // Cycle
   input  wire logic        wb_stb_i,              // Strobe
   input  wire logic [31:0] wb_dat_o,              // Read data
   input  wire logic        wb_ack_o,              // Ack
   input  wire logic        irq_o,                 // Interrupt
   input  wire logic        chip_select_n_i,       // Select
   input  wire logic        ctrl_data_out_oe_o,    // Data out enable
   input  wire logic        int_n_o,               // Int drive level
   input  wire logic        int_n_oe_o,            // Int enable
   input  wire logic        chip_reset_n_i,        // Device reset
   input  wire logic [1:0]  line_state_ctl_a_o,    // Line a
   input  wire logic [1:0]  line_state_ctl_b_o,    // Line b
   input  wire logic [1:0]  line_state_ctl_c_o,    // Line c
   input  wire logic        regulator_clock_out_o  // Regulator clock
);
   logic [8:0] gap_q;
   logic       seen_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Gap since last toggle; saturates so a long stop cannot wrap short
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_q  <= 9'h000;
         seen_q <= 1'b0;
      end else if (!chip_reset_n_i) begin
         gap_q  <= 9'h000;
         seen_q <= 1'b0;
      end else if ($changed(regulator_clock_out_o)) begin
         gap_q  <= 9'h000;
         seen_q <= 1'b1;
      end else if (gap_q != 9'h1FF) begin
         gap_q  <= gap_q + 9'h001;
      end
   end
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_follow; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_follow: assert property (p_ack_follow) else $error("request not acked");
   property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_hold;
      disable iff (rst_i || !chip_reset_n_i) !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
   property p_cs_release; chip_select_n_i [*5] |-> !ctrl_data_out_oe_o; endproperty
   a_cs_release: assert property (p_cs_release) else $error("data out driven unselected");
   property p_int_level;
      int_n_oe_o |-> int_n_o == !irq_o;
   endproperty
   a_int_level: assert property (p_int_level) else $error("int pin disagrees with irq");
   property p_soft_reset;
      !chip_reset_n_i [*4] |-> line_state_ctl_a_o == 2'h0 && line_state_ctl_b_o == 2'h0
         && line_state_ctl_c_o == 2'h0 && !regulator_clock_out_o && !irq_o;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("outputs live in reset");
   property p_regclk; $changed(regulator_clock_out_o) && seen_q |-> gap_q >= 9'h04D; endproperty
   a_regclk: assert property (p_regclk) else $error("regulator half period short");
endmodule
`default_nettype wire

/* tb/vcp_host_model.sv */
// Purpose: Host processor on the serial control port
// Assumes: Shift clock period 200 ns, idle low between frames
// Notes:   Separate data wires, so the shared-wire bit is never needed
`timescale 1ns/1ps
`default_nettype none
module vcp_host_model (
   output logic      sck_o,    // Shift clock
   output logic      sdi_o,    // Data to device
   output logic      cs_n_o,   // Chip select
   input  wire logic sdo_i,    // Data from device
   input  wire logic sdo_oe_i  // Device drive enable
);
   initial begin
      sck_o  = 1'b0;
      sdi_o  = 1'b0;
      cs_n_o = 1'b1;
   end
   // Shared wire not used, device config two bit7 free to set
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic sel_n);
      #5 cs_n_o = sel_n; // Off the sampling edge; frame only while select low
      #200;
      for (int i = 7; i >= 0; i--) begin
         sdi_o = tx[i]; // MSB first
         #100 sck_o = 1'b1;
         rx[i] = sdo_oe_i ? sdo_i : 1'bz;
         #100 sck_o = 1'b0;
      end
      #100 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #200;
   endtask
   // In-band the data output is left unread
   task automatic set_straps(input logic s0, input logic s1);
      #5 sck_o = s0;
      sdi_o = s1;
   endtask
endmodule
`default_nettype wire

/* tb/vcp_ctrl_port_tb.sv */
// Purpose: Self-checking bench for the control port block
// Assumes: Wishbone answers one cycle after a request
// Notes:   Highway bit clock runs at 200 ns so the pin syncs see every edge
`timescale 1ns/1ps
`default_nettype none
module vcp_ctrl_port_tb;
   import vcp_pkg::*;
   logic        ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, rx;
   logic [31:0] wdat = 32'h0, rdat;
   logic [1:0]  fault_n = 2'h3;
   logic        chip_rst_n = 1'b1, int_pull = 1'b1;
   logic        hw_clk = 1'b0, hw_sync = 1'b0, hw_rx = 1'b0, hw_t, hw_e;
   logic [23:0] hw_seen, hw_en;
   localparam logic [23:0] HW_RX = 24'h005AC3; // Slot 1 gets 5A, slot 2 gets C3
   wire         tx_hw, tx_hw_oe;
   wire  [31:0] wb_dat;
   wire  [1:0]  la, lb, lc;
   wire  [2:0]  strap;
   wire         wb_ack, irq, sck, sdi, cs_n, sdo, sdo_oe, int_o, int_oe, regclk;
   wire         int_line = int_oe ? int_o : int_pull;
   int          err_count = 0, num_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   vcp_ctrl_port vcp_ctrl_port_inst (.ref_clk_i(ref_clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .irq_o(irq), .ctrl_shift_clock_i(sck),
      .ctrl_data_in_i(sdi), .chip_select_n_i(cs_n), .ctrl_data_out_o(sdo),
      .ctrl_data_out_oe_o(sdo_oe), .int_n_i(int_line), .int_n_o(int_o), .int_n_oe_o(int_oe),
      .chip_reset_n_i(chip_rst_n), .fault_n_i(fault_n), .line_state_ctl_a_o(la),
      .line_state_ctl_b_o(lb), .line_state_ctl_c_o(lc), .regulator_clock_out_o(regclk),
      .pcm_clk_i(hw_clk), .frame_sync_i(hw_sync), .rx_highway_in_i(hw_rx),
      .tx_highway_out_o(tx_hw), .tx_highway_oe_o(tx_hw_oe), .addr_strap_o(strap));
   vcp_host_model host_inst (.sck_o(sck), .sdi_o(sdi), .cs_n_o(cs_n), .sdo_i(sdo),
      .sdo_oe_i(sdo_oe));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rdat = wb_dat;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 50) chk("ack", 32'h1, 32'h0);
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wbx(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wbx(1'b0, a, 32'h0);
      chk(nm, exp, rdat);
   endtask
   task automatic half(input logic [31:0] exp, input string nm);
      logic v;
      int   n;
      for (int k = 0; k < 2; k++) begin
         v = regclk;
         n = 0;
         while (regclk === v && n < 600) begin
            @(posedge ref_clk);
            n++;
         end
      end
      chk(nm, exp, 32'(n));
   endtask
   // One highway bit: rise with sync and data, sample after the pin delay, then fall
   task automatic hw_bit(input logic f, input logic d, output logic t, output logic e);
      @(posedge ref_clk);
      hw_clk <= 1'b1;
      hw_sync <= f;
      hw_rx <= d;
      repeat (4) @(posedge ref_clk);
      t = tx_hw;
      e = tx_hw_oe;
      hw_clk <= 1'b0;
      hw_sync <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      $display("BAD watchdog expected done seen hang");
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(A_CTRL, 32'h0, "ctrl");
      rd(A_STATUS, 32'h0, "status");
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0, "unmapped");
      $display("test reset done");
      wr(A_LINE, 32'h2B);
      chk("line", 32'h27, {26'h0, lc, lb, la});
      $display("test line done");
      wr(A_CFG2, 32'h80);
      wr(A_TXBYTE, 32'hA5);
      host_inst.xfer(8'h3C, rx, 1'b0);
      chk("sdo", 32'hA5, {24'h0, rx});
      rd(A_RXBYTE, 32'h3C, "rxbyte");
      rd(A_STATUS, 32'h1, "done");
      wr(A_CFG2, 32'h0);
      host_inst.xfer(8'hC3, rx, 1'b1);
      rd(A_RXBYTE, 32'h3C, "ignored");
      $display("test serial done");
      wr(A_MASK, 32'h1);
      chk("int", 32'h6, {29'h0, irq, int_oe, int_o});
      wr(A_STATUS, 32'h1);
      chk("int_clr", 32'h1, {29'h0, irq, int_oe, int_o});
      wr(A_CTRL, 32'h2);
      chk("int_pp", 32'h3, {29'h0, irq, int_oe, int_o});
      fault_n <= 2'h1;
      repeat (6) @(posedge ref_clk);
      rd(A_STATUS, 32'h4, "fault");
      wr(A_MASK, 32'h4);
      chk("irq_flt", 32'h1, {31'h0, irq});
      fault_n <= 2'h3;
      repeat (6) @(posedge ref_clk);
      wr(A_STATUS, 32'h4);
      chk("irq_off", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      wr(A_CTRL, 32'h1);
      host_inst.set_straps(1'b1, 1'b0);
      repeat (6) @(posedge ref_clk);
      chk("strap", 32'h5, {29'h0, strap});
      int_pull <= 1'b0;
      host_inst.set_straps(1'b0, 1'b1);
      repeat (6) @(posedge ref_clk);
      chk("strap2", 32'h2, {29'h0, strap});
      chk("oe_inband", 32'h0, {30'h0, sdo_oe, int_oe});
      int_pull <= 1'b1;
      host_inst.set_straps(1'b0, 1'b0);
      $display("test inband done");
      wr(A_CTRL, 32'h8);
      half(32'(REG_FAST_HALF), "fast");
      wr(A_CTRL, 32'hC);
      half(32'(REG_SLOW_HALF), "slow");
      $display("test regulator done");
      wr(A_SLOTS, 32'h0201);
      wr(A_TXSAMP, 32'h3CA5);
      for (int p = 0; p < 24; p++) begin
         hw_bit(p == 0, HW_RX[23 - p], hw_t, hw_e);
         hw_seen[23 - p] = hw_t & hw_e;
         hw_en[23 - p] = hw_e;
      end
      chk("hw_tx", 32'h0000A53C, {8'h00, hw_seen});
      chk("hw_oe", 32'h0000FFFF, {8'h00, hw_en});
      rd(A_RXSAMP, 32'hC35A, "rxsamp");
      $display("test highway done");
      chip_rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("soft_rst", 32'h0, {25'h0, regclk, lc, lb, la});
      rd(A_LINE, 32'h0, "line_rst");
      chip_rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      $display("test chip reset done");
      report_and_stop;
   end
endmodule
bind vcp_ctrl_port vcp_ctrl_port_checker vcp_ctrl_port_checker_inst (.ref_clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .irq_o, .chip_select_n_i, .ctrl_data_out_oe_o,
   .int_n_o, .int_n_oe_o, .chip_reset_n_i, .line_state_ctl_a_o, .line_state_ctl_b_o,
   .line_state_ctl_c_o, .regulator_clock_out_o);
`default_nettype wire
